// *** logic/sbc_defines.vh ***
// Constants shared by the bank command state machine and its decoder.
// Assumes inclusion by bare name from files under logic/.
`ifndef SBC_DEFINES_VH
`define SBC_DEFINES_VH

// Decoded command codes
`define SBC_CMD_W        4
`define SBC_CMD_CHIP_UNSELECTED_CMD     4'h0
`define SBC_CMD_NOP      4'h1
`define SBC_CMD_HALT     4'h2
`define SBC_CMD_FETCH    4'h3
`define SBC_CMD_STORE    4'h4
`define SBC_CMD_OPEN     4'h5
`define SBC_CMD_CLOSE    4'h6
`define SBC_CMD_REFRESH  4'h7
`define SBC_CMD_MODE     4'h8

// Bank states
`define SBC_ST_W         3
`define SBC_ST_IDLE      3'h0
`define SBC_ST_ROW       3'h1
`define SBC_ST_READ      3'h2
`define SBC_ST_WRITE     3'h3
`define SBC_ST_READ_AC   3'h4
`define SBC_ST_WREC      3'h5
`define SBC_ST_PRECHG    3'h6

// Synchronised pin vector layout
`define SBC_PIN_W        15
`define SBC_PIN_CKE      14
`define SBC_PIN_CS       13
`define SBC_PIN_RAS      12
`define SBC_PIN_CAS      11
`define SBC_PIN_WE       10
`define SBC_PIN_BANK     9
`define SBC_PIN_A8       8
`define SBC_PIN_COL_HI   7
`define SBC_PIN_COL_LO   0
`define SBC_PIN_RESET    15'h7c00

// Widths and reset values
`define SBC_ADDR_W       10
`define SBC_COL_W        8
`define SBC_CNT_W        8
`define SBC_ADDR_RESET   10'h000
`define SBC_COL_RESET    8'h00
`define SBC_CNT_ZERO     8'h00
`define SBC_CNT_ONE      8'h01

`endif

// *** logic/sbc_cmd_decode.v ***
// Command decoder: strobe pins to a command code.
// Assumes the strobes are already synchronised to the bank clock.
`timescale 1ns/10ps
`include "sbc_defines.vh"

module sbc_cmd_decode (
   cs_n,
   ras_n,
   cas_n,
   we_n,
   cmd
);
   input  wire                  cs_n;
   input  wire                  ras_n;
   input  wire                  cas_n;
   input  wire                  we_n;
   output reg  [`SBC_CMD_W-1:0] cmd;

   always @* begin
      if (cs_n) begin
         cmd = `SBC_CMD_CHIP_UNSELECTED_CMD;
      end else begin
         case ({ras_n, cas_n, we_n})
            3'b111:  cmd = `SBC_CMD_NOP;
            3'b110:  cmd = `SBC_CMD_HALT;
            3'b101:  cmd = `SBC_CMD_FETCH;
            3'b100:  cmd = `SBC_CMD_STORE;
            3'b011:  cmd = `SBC_CMD_OPEN;
            3'b010:  cmd = `SBC_CMD_CLOSE;
            3'b001:  cmd = `SBC_CMD_REFRESH;
            default: cmd = `SBC_CMD_MODE;
         endcase
      end
   end

endmodule // sbc_cmd_decode

// *** logic/sbc_bank_fsm.v ***
// One bank's command state machine of a two-bank synchronous DRAM.
// Assumes pins arrive asynchronously and a controller tracks bank state.
//
// Function
// - Idle: no-ops, power-down, open, refresh, mode load
// - Read burst continues, then returns to open row
// - Halt during read returns to open row
// - New read during read restarts at new column
// - Write during read starts write burst
// - Close interrupts read; open/refresh/mode illegal
// - Write burst continues, then write recovery
// - Halt during write returns to open row
// - Read during write starts read burst
// - New write during write restarts at column
// - Close interrupts write; open/refresh/mode illegal
// - Autoclose read finishes then precharges; others illegal
// - Halted read stops data after column latency
// - Clock gating low holds power-down, inputs ignored
`timescale 1ns/10ps
`include "sbc_defines.vh"

module sbc_bank_fsm #(
   parameter                  BANK_ID   = 0,
   parameter [`SBC_CNT_W-1:0] BURST_LEN = 8'h04,
   parameter                  COL_LAT   = 2,
   parameter [`SBC_CNT_W-1:0] WREC_CYC  = 8'h02,
   parameter [`SBC_CNT_W-1:0] PRECH_CYC = 8'h03
) (
   clk,
   rst,
   cke,
   cs_n,
   ras_n,
   cas_n,
   we_n,
   addr,
   state_q,
   col_addr_q,
   row_addr_q,
   mode_q,
   read_beat_q,
   write_beat_q,
   dq_oe_q,
   refresh_q,
   mode_load_q,
   power_down_q,
   illegal_q
);
   input  wire                   clk;
   input  wire                   rst;
   input  wire                   cke;
   input  wire                   cs_n;
   input  wire                   ras_n;
   input  wire                   cas_n;
   input  wire                   we_n;
   input  wire [`SBC_ADDR_W-1:0] addr;
   output reg  [`SBC_ST_W-1:0]   state_q;
   output reg  [`SBC_COL_W-1:0]  col_addr_q;
   output reg  [`SBC_ADDR_W-2:0] row_addr_q;
   output reg  [`SBC_ADDR_W-1:0] mode_q;
   output reg                    read_beat_q;
   output reg                    write_beat_q;
   output reg                    dq_oe_q;
   output reg                    refresh_q;
   output reg                    mode_load_q;
   output reg                    power_down_q;
   output reg                    illegal_q;

   localparam [`SBC_CNT_W-1:0] BL_LAST    = BURST_LEN - `SBC_CNT_ONE;
   localparam [`SBC_CNT_W-1:0] WREC_LAST  = WREC_CYC - `SBC_CNT_ONE;
   localparam [`SBC_CNT_W-1:0] PRECH_LAST = PRECH_CYC - `SBC_CNT_ONE;
   localparam                  BANK_BIT   = (BANK_ID != 0);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   ////////////////////////////////////////////////////////////////////////
   // The controller's clock is unrelated, so every pin passes two stages.
   reg  [`SBC_PIN_W-1:0] pin_meta_q;
   reg  [`SBC_PIN_W-1:0] pin_q;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_meta_q <= `SBC_PIN_RESET;
         pin_q      <= `SBC_PIN_RESET;
      end else begin
         pin_meta_q <= {cke, cs_n, ras_n, cas_n, we_n, addr};
         pin_q      <= pin_meta_q;
      end
   end

   wire [`SBC_CMD_W-1:0]  cmd;
   wire [`SBC_COL_W-1:0]  pin_col = pin_q[`SBC_PIN_COL_HI:`SBC_PIN_COL_LO];
   wire                   pin_ac  = pin_q[`SBC_PIN_A8];

   sbc_cmd_decode u_decode (
      .cs_n  (pin_q[`SBC_PIN_CS]),
      .ras_n (pin_q[`SBC_PIN_RAS]),
      .cas_n (pin_q[`SBC_PIN_CAS]),
      .we_n  (pin_q[`SBC_PIN_WE]),
      .cmd   (cmd)
   );

   ////////////////////////////////////////////////////////////////////////
   // Command targeting
   ////////////////////////////////////////////////////////////////////////
   // Bank-addressed commands aimed at the other bank are a no-op here.
   function to_me;
      input [`SBC_CMD_W-1:0]  c;
      input [`SBC_PIN_W-1:0]  p;
      begin
         if (c == `SBC_CMD_CLOSE)
            to_me = p[`SBC_PIN_A8] | (p[`SBC_PIN_BANK] == BANK_BIT);
         else
            to_me = (p[`SBC_PIN_BANK] == BANK_BIT);
      end
   endfunction

   wire is_fetch = (cmd == `SBC_CMD_FETCH) & to_me(cmd, pin_q);
   wire is_store = (cmd == `SBC_CMD_STORE) & to_me(cmd, pin_q);
   wire is_open  = (cmd == `SBC_CMD_OPEN)  & to_me(cmd, pin_q);
   wire is_close = (cmd == `SBC_CMD_CLOSE) & to_me(cmd, pin_q);
   wire is_halt  = (cmd == `SBC_CMD_HALT);
   wire is_ref   = (cmd == `SBC_CMD_REFRESH);
   wire is_mode  = (cmd == `SBC_CMD_MODE);

   ////////////////////////////////////////////////////////////////////////
   // Power-down and clock suspend
   ////////////////////////////////////////////////////////////////////////
   wire pin_cke = pin_q[`SBC_PIN_CKE];
   reg  cke_prev_q;
   reg  freeze_d;

   always @* begin
      // Entry needs a high-to-low edge; staying low keeps it held
      freeze_d = (cke_prev_q & ~pin_cke) | (power_down_q & ~pin_cke);
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cke_prev_q   <= 1'b1;
         power_down_q <= 1'b0;
      end else begin
         cke_prev_q   <= pin_cke;
         power_down_q <= freeze_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bank state machine
   ////////////////////////////////////////////////////////////////////////
   reg  [`SBC_ST_W-1:0]  state_d;
   reg  [`SBC_CNT_W-1:0] cnt_q;
   reg  [`SBC_CNT_W-1:0] cnt_d;
   reg  [`SBC_COL_W-1:0] col_d;
   reg  [`SBC_ADDR_W-2:0] row_d;
   reg  [`SBC_ADDR_W-1:0] mode_d;
   reg                   ac_q;
   reg                   ac_d;
   reg                   rd_d;
   reg                   wr_d;
   reg                   ref_d;
   reg                   mode_ld_d;
   reg                   ill_d;

   // Column command start shared by open-row, read, write and recovery
   task start_col;
      begin
         col_d = pin_col;
         cnt_d = BL_LAST;
         ac_d  = pin_ac;
         if (is_fetch) begin
            state_d = pin_ac ? `SBC_ST_READ_AC : `SBC_ST_READ;
            rd_d    = 1'b1;
         end else begin
            state_d = `SBC_ST_WRITE;
            wr_d    = 1'b1;
         end
      end
   endtask

   // Report whether the burst counter has reached zero; the caller advances it
   function burst_done;
      input [`SBC_CNT_W-1:0] c;
      begin
         burst_done = (c == `SBC_CNT_ZERO);
      end
   endfunction

   always @* begin
      state_d   = state_q;
      cnt_d     = cnt_q;
      col_d     = col_addr_q;
      row_d     = row_addr_q;
      mode_d    = mode_q;
      ac_d      = ac_q;
      rd_d      = 1'b0;
      wr_d      = 1'b0;
      ref_d     = 1'b0;
      mode_ld_d = 1'b0;
      ill_d     = 1'b0;
      if (!freeze_d) begin
         case (state_q)
            `SBC_ST_IDLE: begin
               if (is_open) begin
                  state_d = `SBC_ST_ROW;
                  row_d   = pin_q[`SBC_ADDR_W-2:0];
               end else if (is_ref) begin
                  ref_d = 1'b1;
               end else if (is_mode) begin
                  mode_d    = pin_q[`SBC_ADDR_W-1:0];
                  mode_ld_d = 1'b1;
               end else if (is_fetch | is_store) begin
                  ill_d = 1'b1;
               end
            end
            `SBC_ST_ROW: begin
               if (is_fetch | is_store) begin
                  start_col;
               end else if (is_close) begin
                  state_d = `SBC_ST_PRECHG;
                  cnt_d   = PRECH_LAST;
               end else if (is_open | is_ref | is_mode) begin
                  ill_d = 1'b1;
               end
            end
            `SBC_ST_READ, `SBC_ST_WRITE: begin
               if (is_halt) begin
                  state_d = `SBC_ST_ROW;
               end else if (is_fetch | is_store) begin
                  start_col;
               end else if (is_close) begin
                  state_d = `SBC_ST_PRECHG;
                  cnt_d   = PRECH_LAST;
               end else begin
                  ill_d = is_open | is_ref | is_mode;
                  if (burst_done(cnt_q)) begin
                     if (state_q == `SBC_ST_READ) begin
                        state_d = `SBC_ST_ROW;
                     end else begin
                        state_d = `SBC_ST_WREC;
                        cnt_d   = WREC_LAST;
                     end
                  end else begin
                     cnt_d = cnt_q - `SBC_CNT_ONE;
                     col_d = col_addr_q + `SBC_COL_RESET + 8'h01;
                     rd_d  = (state_q == `SBC_ST_READ);
                     wr_d  = (state_q == `SBC_ST_WRITE);
                  end
               end
            end
            `SBC_ST_READ_AC: begin
               // Only no-ops and deselects are legal until the autoclose ends
               ill_d = is_halt | is_fetch | is_store | is_open
                     | is_close | is_ref | is_mode;
               if (burst_done(cnt_q)) begin
                  state_d = `SBC_ST_PRECHG;
                  cnt_d   = PRECH_LAST;
               end else begin
                  cnt_d = cnt_q - `SBC_CNT_ONE;
                  col_d = col_addr_q + 8'h01;
                  rd_d  = 1'b1;
               end
            end
            `SBC_ST_WREC: begin
               if ((is_fetch | is_store) & ~ac_q) begin
                  start_col;
               end else if (burst_done(cnt_q)) begin
                  state_d = ac_q ? `SBC_ST_PRECHG : `SBC_ST_ROW;
                  cnt_d   = PRECH_LAST;
               end else begin
                  ill_d = is_open | is_close | is_ref | is_mode;
                  cnt_d = cnt_q - `SBC_CNT_ONE;
               end
            end
            `SBC_ST_PRECHG: begin
               ill_d = is_fetch | is_store | is_open | is_ref | is_mode;
               if (burst_done(cnt_q)) begin
                  state_d = `SBC_ST_IDLE;
                  ac_d    = 1'b0;
               end else begin
                  cnt_d = cnt_q - `SBC_CNT_ONE;
               end
            end
            default: begin
               state_d = `SBC_ST_IDLE;
            end
         endcase
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q      <= `SBC_ST_IDLE;
         cnt_q        <= `SBC_CNT_ZERO;
         col_addr_q   <= `SBC_COL_RESET;
         row_addr_q   <= 9'h000;
         mode_q       <= `SBC_ADDR_RESET;
         ac_q         <= 1'b0;
         read_beat_q  <= 1'b0;
         write_beat_q <= 1'b0;
         refresh_q    <= 1'b0;
         mode_load_q  <= 1'b0;
         illegal_q    <= 1'b0;
      end else begin
         state_q      <= state_d;
         cnt_q        <= cnt_d;
         col_addr_q   <= col_d;
         row_addr_q   <= row_d;
         mode_q       <= mode_d;
         ac_q         <= ac_d;
         read_beat_q  <= rd_d;
         write_beat_q <= wr_d;
         refresh_q    <= ref_d;
         mode_load_q  <= mode_ld_d;
         illegal_q    <= ill_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data output latency
   ////////////////////////////////////////////////////////////////////////
   // A halted read keeps driving the beats already in flight, so the
   // output enable falls only after the column latency has run out.
   reg [COL_LAT-1:0] rd_pipe_q;

   always @(posedge clk or posedge rst) begin
      if (rst)
         rd_pipe_q[0] <= 1'b0;
      else if (!power_down_q)
         rd_pipe_q[0] <= read_beat_q;
   end

   genvar gi;
   generate
      for (gi = 1; gi < COL_LAT; gi = gi + 1) begin : g_lat
         always @(posedge clk or posedge rst) begin
            if (rst)
               rd_pipe_q[gi] <= 1'b0;
            else if (!power_down_q)
               rd_pipe_q[gi] <= rd_pipe_q[gi-1];
         end
      end
   endgenerate

   always @(posedge clk or posedge rst) begin
      if (rst)
         dq_oe_q <= 1'b0;
      else
         dq_oe_q <= rd_pipe_q[COL_LAT-1];
   end

endmodule // sbc_bank_fsm

// *** verification/sbc_bank_fsm_chk.sv ***
// Checker for the bank state machine: timing relations among its outputs.
// Assumes the bind below and the shared constants header on the include path.
`timescale 1ns/10ps
`include "sbc_defines.vh"
////////////////////////////////////////////////
module sbc_bank_fsm_chk #(
   parameter COL_LAT = 2
) (
   input logic       clk,
   input logic       rst,
   input logic [2:0] state_q,
   input logic       read_beat_q,
   input logic       write_beat_q,
   input logic       dq_oe_q,
   input logic       refresh_q,
   input logic       mode_load_q,
   input logic       power_down_q,
   input logic       illegal_q
);
   localparam int DQ_DLY = COL_LAT + 1;
   logic [2:0] since_q;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Keeps $past from looking back across a reset
   always @(posedge clk or posedge rst) begin
      if (rst) since_q <= 3'h0;
      else if (since_q != 3'h7) since_q <= since_q + 3'h1;
   end
   a_refresh_idle:
      assert property (refresh_q |-> $past(state_q) == `SBC_ST_IDLE)
      else $error("refresh pulse outside idle");
   a_mode_idle:
      assert property (mode_load_q |-> $past(state_q) == `SBC_ST_IDLE)
      else $error("mode load pulse outside idle");
   a_read_beat_st:
      assert property (read_beat_q |-> state_q inside {`SBC_ST_READ, `SBC_ST_READ_AC})
      else $error("read beat outside a read burst");
   a_write_beat_st:
      assert property (write_beat_q |-> state_q == `SBC_ST_WRITE)
      else $error("write beat outside a write burst");
   a_dq_follow:
      assert property (since_q == 3'h7 |-> dq_oe_q == $past(read_beat_q, DQ_DLY))
      else $error("data drive does not trail read beats");
   a_pd_freeze:
      assert property (power_down_q && $past(power_down_q) |-> $stable(state_q))
      else $error("state moved while powered down");
   a_illegal_hold:
      assert property (illegal_q && $past(state_q) <= `SBC_ST_ROW |-> $stable(state_q))
      else $error("illegal command changed state");
   // Three cycles is the precharge length the bench sets
   a_prech_len:
      assert property ($rose(state_q == `SBC_ST_PRECHG) && !power_down_q |->
         (state_q == `SBC_ST_PRECHG)[*3] ##1 state_q == `SBC_ST_IDLE)
      else $error("precharge length wrong");
   c_read: cover property ($rose(state_q == `SBC_ST_READ));
   c_prech: cover property ($rose(state_q == `SBC_ST_PRECHG));
   c_pdown: cover property ($rose(power_down_q));
   c_illegal: cover property (illegal_q);
endmodule // sbc_bank_fsm_chk

bind sbc_bank_fsm sbc_bank_fsm_chk #(.COL_LAT(COL_LAT)) chk_u (
   .clk          (clk),
   .rst          (rst),
   .state_q      (state_q),
   .read_beat_q  (read_beat_q),
   .write_beat_q (write_beat_q),
   .dq_oe_q      (dq_oe_q),
   .refresh_q    (refresh_q),
   .mode_load_q  (mode_load_q),
   .power_down_q (power_down_q),
   .illegal_q    (illegal_q)
);

// *** verification/sbc_ctl_model.sv ***
// Memory controller model: one command code a cycle onto the strobe pins.
// Assumes the bench asks only for commands legal in the bank state, unless on purpose.
`timescale 1ns/10ps
`include "sbc_defines.vh"
////////////////////////////////////////////////
module sbc_ctl_model (
   input  logic       clk,
   input  logic       go,
   input  logic       ck,
   input  logic [3:0] cmd,
   input  logic [9:0] a,
   output logic       cke,
   output logic       cs_n,
   output logic       ras_n,
   output logic       cas_n,
   output logic       we_n,
   output logic [9:0] addr
);
   initial begin
      {cke, cs_n, ras_n, cas_n, we_n} = 5'h1f;
      addr = 10'h000;
   end
   always @(posedge clk) begin
      cke <= ck;
      if (go && cmd != `SBC_CMD_CHIP_UNSELECTED_CMD) begin
         cs_n <= 1'b0;
         // Codes one to eight are the inverted strobe triple of code minus one
         {ras_n, cas_n, we_n} <= ~3'(cmd - 4'h1);
         addr <= a;
      end else begin
         // Deselected lines carry nothing, so keep them moving
         cs_n <= 1'b1;
         {ras_n, cas_n, we_n} <= ~{ras_n, cas_n, we_n};
         addr <= ~addr;
      end
   end
endmodule // sbc_ctl_model

// *** verification/tb_sbc_bank_fsm.sv ***
// Bench: a reference model steps on the same pins as the bank machine and is compared.
// Assumes the controller model and the checker bind are compiled alongside.
`timescale 1ns/10ps
`include "sbc_defines.vh"
////////////////////////////////////////////////
module tb_sbc_bank_fsm;
   localparam logic [7:0] BL = 8'h04, WR = 8'h02, PR = 8'h03;
   logic        clk, rst, go, ck, cke, cs_n, ras_n, cas_n, we_n;
   logic [3:0]  cmd;
   logic [9:0]  a, addr;
   logic [2:0]  state_q, sh;
   logic [7:0]  col_addr_q;
   logic [8:0]  row_addr_q;
   logic [9:0]  mode_q;
   logic        read_beat_q, write_beat_q, dq_oe_q, refresh_q;
   logic        mode_load_q, power_down_q, illegal_q, rb, wb, il, rf, ml;
   logic [14:0] p1, p2;
   logic [31:0] rnd = 32'h0000_0008;
   int          st, cnt, col, t, ac, c, hit, n_fail, cmp_count, row, md;

   sbc_ctl_model ctl_u (.clk(clk), .go(go), .ck(ck), .cmd(cmd), .a(a), .cke(cke),
      .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr));
   sbc_bank_fsm #(.BURST_LEN(BL), .COL_LAT(2), .WREC_CYC(WR), .PRECH_CYC(PR)) dut_u (
      .clk(clk), .rst(rst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
      .we_n(we_n), .addr(addr), .state_q(state_q), .col_addr_q(col_addr_q),
      .row_addr_q(row_addr_q), .mode_q(mode_q), .read_beat_q(read_beat_q),
      .write_beat_q(write_beat_q),
      .dq_oe_q(dq_oe_q), .refresh_q(refresh_q), .mode_load_q(mode_load_q),
      .power_down_q(power_down_q), .illegal_q(illegal_q));

   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   task automatic chk(input string nm, input logic [9:0] seen, input int exp);
      cmp_count++;
      if (seen !== exp[9:0]) begin
         n_fail++;
         $display("BAD %s expected %0d seen %0d", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Digits are command codes; a/b fetch/store with autoclose; x opens the
   // other bank; p drops clock gating; q drops it and sends an open
   task automatic run(input string s);
      byte ch;
      for (int i = 0; i < s.len(); i++) begin
         ch = s[i];
         @(posedge clk);
         rnd = xs(rnd);
         ck <= !(ch == "p" || ch == "q");
         go <= ch != "p";
         cmd <= ch == "a" ? 4'h3 : ch == "b" ? 4'h4 :
                ch == "x" || ch == "q" ? 4'h5 : 4'(ch - "0");
         a <= {ch == "x", ch == "a" || ch == "b", rnd[7:0]};
         if (ch == "q") begin
            #1;
            chk("pdown", power_down_q, 1);
         end
      end
   endtask

   ////////////////////////////////////////////////
   // Reference model; pins pass two stages, as in the design's synchronisers
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         p1 <= `SBC_PIN_RESET;
         p2 <= `SBC_PIN_RESET;
         {rb, wb, il, rf, ml, sh} = 8'h00;
         st = 0;
         row = 0;
         md = 0;
      end else begin
         p1 <= {cke, cs_n, ras_n, cas_n, we_n, addr};
         p2 <= p1;
         sh = {sh[1:0], rb};
         c = p2[13] ? 0 : 8 - p2[12:10];
         hit = !p2[9] || (c == 6 && p2[8]);
         {rb, wb, il, rf, ml} = 5'h00;
         if (!p2[14]) begin
            // Powered down: pins ignored, state held
         end else if (st == 0) begin
            rf = c == 7;
            ml = c == 8;
            il = hit && (c == 3 || c == 4);
            if (ml) md = p2[9:0];
            if (c == 5 && hit) begin
               st = 1;
               row = p2[8:0];
            end
         end else if ((st < 4 || (st == 5 && ac == 0)) && hit && (c == 3 || c == 4)) begin
            col = p2[7:0];
            cnt = BL - 1;
            ac = p2[8];
            rb = c == 3;
            wb = c == 4;
            st = c == 4 ? 3 : p2[8] ? 4 : 2;
         end else if (st < 4 && hit && c == 6) begin
            st = 6;
            t = PR - 1;
         end else if (st == 1 || (st < 4 && c == 2)) begin
            il = st == 1 && ((c == 5 && hit) || c > 6);
            st = 1;
         end else if (st < 5) begin
            il = st == 4 ? c > 1 : (c == 5 && hit) || c > 6;
            if (cnt > 0) begin
               cnt--;
               col = (col + 1) % 256;
               rb = st != 3;
               wb = st == 3;
            end else begin
               st = st == 2 ? 1 : st == 3 ? 5 : 6;
               t = st == 6 ? PR - 1 : WR - 1;
            end
         end else begin
            // Recovery flags only while still counting; precharge always
            il = st == 6 ? (hit && c > 2 && c < 6) || c > 6
                         : t > 0 && ((hit && (c == 5 || c == 6)) || c > 6);
            if (t > 0) t--;
            else begin
               st = st == 6 ? 0 : ac ? 6 : 1;
               t = PR - 1;
            end
         end
      end
   end
   always @(negedge clk) begin
      if (!rst) begin
         chk("state", state_q, st);
         chk("rbeat", read_beat_q, rb);
         chk("wbeat", write_beat_q, wb);
         chk("illegal", illegal_q, il);
         chk("refresh", refresh_q, rf);
         chk("mload", mode_load_q, ml);
         chk("dq_oe", dq_oe_q, sh[2]);
         chk("row", row_addr_q, row);
         chk("mode", mode_q, md);
         if (rb || wb) chk("col", col_addr_q, col);
      end
   end

   ////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      #50000;
      n_fail++;
      tally_and_finish;
   end
   initial begin
      rst = 1'b1;
      {go, cmd, a} = 15'h0000;
      ck = 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      run("12063478x");
      run("pppppq111");
      run("53111111");
      run("312111");
      run("33111111");
      run("3411111111");
      run("42114311111111");
      run("441111111111");
      run("357861111111");
      run("5578418761111111");
      run("5a2341111111");
      run("5b1111111111111");
      run("541111531111631111");
      chk("pdown", power_down_q, 0);
      tally_and_finish;
   end
endmodule // tb_sbc_bank_fsm
